// ===== design/csc_pkg.sv
package csc_pkg;

    // clock rate and derived cycle counts
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned BRAKE_PULSE_MS   = 2;       // braking pulse after pawl delay
    localparam int unsigned SETTLE_MS        = 10;      // lock to ready settling time
    localparam int unsigned PURGE_S          = 52;      // purge and brush clean delay
    localparam int unsigned BRAKE_PULSE_CYC  = CLK_HZ / 1000 * BRAKE_PULSE_MS;
    localparam int unsigned SETTLE_CYC       = CLK_HZ / 1000 * SETTLE_MS;
    localparam longint unsigned PURGE_CYC    = longint'(CLK_HZ) * PURGE_S;

    // cylinder thresholds of the velocity profile
    localparam int unsigned TRK_W            = 8;       // counter width, holds 203 positions
    localparam int unsigned TRK_RING         = 203;     // track ring positions
    localparam logic [7:0]  THR_FULL         = 8'h40;   // 64 cylinders
    localparam logic [7:0]  THR_MID          = 8'h10;   // 16 cylinders
    localparam logic [7:0]  THR_FINE_DEF     = 8'h04;   // default 6 to 2 ips switch point
    localparam logic [7:0]  CNT_ONE          = 8'h01;
    localparam logic [7:0]  CNT_ZERO         = 8'h00;

    // speed ring: 1020 slots; interval between pulses gives velocity
    localparam int unsigned SPD_RING         = 1020;
    localparam int unsigned IVL_W            = 24;      // interval counter width

    // target speed in ips, coded as interval thresholds (parameters in top)
    localparam logic [1:0]  SPD_15           = 2'h0;
    localparam logic [1:0]  SPD_6            = 2'h1;
    localparam logic [1:0]  SPD_2            = 2'h2;

    // seek sequencer states
    typedef enum logic [3:0] {
        CSC_IDLE    = 4'b0000,  // locked, waiting for a move
        CSC_UNLOCK  = 4'b0001,  // detent energised, pawl withdrawing
        CSC_FULL    = 4'b0010,  // full current, no velocity limit
        CSC_SERVO   = 4'b0011,  // speed-servoed approach
        CSC_STOP    = 4'b0100,  // stop pending, waiting last pulse
        CSC_LOCKDLY = 4'b0101,  // pawl falling, delay running
        CSC_BRAKE   = 4'b0110,  // high-current braking pulse
        CSC_SETTLE  = 4'b0111,  // waiting for settling to finish
        CSC_PURGE   = 4'b1000,  // spin-up purge delay
        CSC_LOADFWD = 4'b1001,  // first seek forward, loading heads
        CSC_HOMEREV = 4'b1010,  // first seek reverse to home
        CSC_HOMEFWD = 4'b1011,  // forward at 2 ips to cylinder 00
        CSC_UNLOAD  = 4'b1100   // heads unloading, carriage reversing to home
    } csc_state_e;

    // move command from the controller
    typedef struct packed {
        logic             fwd;    // 1 = toward spindle
        logic [TRK_W-1:0] count;  // tracks to move
    } csc_cmd_s;

    // motor drive to the amplifier
    typedef struct packed {
        logic on;      // current applied
        logic fwd;     // polarity: 1 forward, 0 reverse
        logic full;    // maximum amplitude
    } csc_motor_s;

endpackage : csc_pkg

// ===== design/csc_speed_meter.sv
// measures the interval between speed ring pulses and decides whether the
// carriage runs faster than the selected target; the interval is the period
// of the ring, so a longer interval means slower motion
module csc_speed_meter #(
    parameter int unsigned IVL_W = 24              // interval counter width
) (
    input  wire logic             clk,            // system clock
    input  wire logic             rst_n,          // synchronous reset, active low
    input  wire logic             spd_pulse,      // synchronised speed ring level
    input  wire logic [IVL_W-1:0] target_ivl,     // interval at the target speed
    output logic                  too_fast,       // last interval below target
    output logic [IVL_W-1:0]      ivl_out         // last measured interval
);
    logic             prev_reg, prev_next;         // previous ring level
    logic [IVL_W-1:0] cnt_reg, cnt_next;           // running interval count
    logic [IVL_W-1:0] ivl_reg, ivl_next;           // latched interval
    logic             fast_reg, fast_next;         // comparison result

    // next-value logic: count up, latch on each rising edge of the ring
    always_comb begin
        prev_next = spd_pulse;
        cnt_next  = cnt_reg;
        ivl_next  = ivl_reg;
        fast_next = fast_reg;
        if (spd_pulse && !prev_reg) begin
            ivl_next  = cnt_reg;
            fast_next = (cnt_reg < target_ivl);
            cnt_next  = '0;
        end else if (cnt_reg != '1) begin
            // saturate so a stalled carriage reads as slow, not as fast
            cnt_next = cnt_reg + 1'b1;
        end
        // a stalled carriage must not keep an old fast verdict
        if (cnt_reg >= target_ivl) begin
            fast_next = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
            cnt_reg  <= '0;
            ivl_reg  <= '1;
            fast_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            cnt_reg  <= cnt_next;
            ivl_reg  <= ivl_next;
            fast_reg <= fast_next;
        end
    end

    assign too_fast = fast_reg;
    assign ivl_out  = ivl_reg;

endmodule : csc_speed_meter

// ===== design/csc_seek_ctrl.sv
module csc_seek_ctrl
    import csc_pkg::*;
#(
    parameter logic [7:0]           THR_FINE  = THR_FINE_DEF,  // 6 to 2 ips switch point
    parameter int unsigned          LOCK_DLY  = 300_000,       // pawl fall delay, cycles
    parameter int unsigned          BRAKE_CYC = BRAKE_PULSE_CYC,
    parameter int unsigned          SET_CYC   = SETTLE_CYC,
    parameter longint unsigned      PRG_CYC   = PURGE_CYC,
    parameter logic [IVL_W-1:0]     IVL_15    = 24'h00_0FA0,   // ring interval at 15 ips
    parameter logic [IVL_W-1:0]     IVL_6     = 24'h00_2710,   // ring interval at 6 ips
    parameter logic [IVL_W-1:0]     IVL_2     = 24'h00_7530    // ring interval at 2 ips
) (
    input  wire logic               clk,           // system clock
    input  wire logic               rst_n,         // synchronous reset, active low
    input  wire logic               move_req,      // one-cycle move command strobe
    input  wire csc_cmd_s           move_cmd,      // count and direction
    input  wire logic               trk_pin,       // track photocell, async
    input  wire logic               spd_pin,       // speed ring photocell, async
    input  wire logic               home_pin,      // home cell, high outside data area
    input  wire logic               rpm1900_pin,   // pack at or above 1900 rpm
    input  wire logic               rpm2400_pin,   // pack at full speed
    input  wire logic               power_ok_pin,  // unit power good
    input  wire logic               loaded_pin,    // heads-loaded switch closed
    input  wire logic               data_req,      // controller asks to read or write
    output csc_motor_s              motor,         // motor drive command
    output logic                    detent_sol,    // detent solenoid, 1 = pawl out
    output logic                    cam_sol,       // cam latch solenoid
    output logic                    latch_sol,     // heads-loaded latch solenoid
    output logic                    drive_ready,   // selected drive ready
    output logic                    data_enable,   // data path may exchange
    output logic                    heads_loaded   // loaded status
);
    import csc_pkg::*;

    localparam int unsigned TMR_W = 33;            // wide enough for the purge delay

    // two-flop synchronisers for all pins; first stage read only by second
    logic [6:0] sync1_reg, sync2_reg;
    logic [6:0] pins;
    assign pins = {trk_pin, spd_pin, home_pin, rpm1900_pin, rpm2400_pin,
                   power_ok_pin, loaded_pin};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end
    logic trk_s, spd_s, home_s, r1900_s, r2400_s, pwr_s, loaded_s;
    assign {trk_s, spd_s, home_s, r1900_s, r2400_s, pwr_s, loaded_s} = sync2_reg;

    // speed measurement for the servo loop
    logic [IVL_W-1:0] target_ivl;                  // interval for the chosen speed
    logic             too_fast;                    // carriage above target speed
    csc_speed_meter #(
        .IVL_W      (IVL_W)
    ) u_speed (
        .clk        (clk),
        .rst_n      (rst_n),
        .spd_pulse  (spd_s),
        .target_ivl (target_ivl),
        .too_fast   (too_fast),
        .ivl_out    ()
    );

    // sequencer state
    csc_state_e       state_reg, state_next;       // sequencer state
    logic [TRK_W-1:0] rem_reg, rem_next;           // tracks remaining
    logic             dir_reg, dir_next;           // 1 = forward
    logic             trk_prev_reg, trk_prev_next; // last track level
    logic [TMR_W-1:0] tmr_reg, tmr_next;           // general timer
    logic [TMR_W-1:0] set_reg, set_next;           // settle timer from lock
    logic             cam_reg, cam_next;           // cam latch drive
    logic             latch_reg, latch_next;       // latch solenoid drive
    logic             ready_reg, ready_next;       // drive ready
    logic             det_reg, det_next;           // detent solenoid
    csc_motor_s       mot_reg, mot_next;           // motor drive
    logic [1:0]       spd_sel_reg, spd_sel_next;   // servo speed select
    logic             first_reg, first_next;       // first seek done once

    logic trk_rise, trk_fall, speed_ok;
    assign trk_rise = trk_s && !trk_prev_reg;      // leading edge of track pulse
    assign trk_fall = !trk_s && trk_prev_reg;      // trailing edge of track pulse
    assign speed_ok = pwr_s && r2400_s;

    // servo target as a ring interval
    always_comb begin
        unique case (spd_sel_reg)
            SPD_15:  target_ivl = IVL_15;
            SPD_6:   target_ivl = IVL_6;
            default: target_ivl = IVL_2;
        endcase
    end

    // sequencer next-state and outputs
    always_comb begin
        state_next    = state_reg;
        rem_next      = rem_reg;
        dir_next      = dir_reg;
        trk_prev_next = trk_s;
        tmr_next      = tmr_reg;
        set_next      = (set_reg != '0) ? set_reg - 1'b1 : set_reg;
        cam_next      = cam_reg;
        latch_next    = latch_reg;
        ready_next    = ready_reg;
        det_next      = det_reg;
        mot_next      = mot_reg;
        spd_sel_next  = spd_sel_reg;
        first_next    = first_reg;
        // latch solenoid enabled once up to speed and loading has begun, dropped on any loss
        latch_next    = speed_ok && first_reg;
        if (state_reg inside {CSC_LOADFWD, CSC_HOMEREV, CSC_HOMEFWD}) begin
            latch_next = speed_ok;
        end
        // speed servo: pulse current so average holds target; braking is
        // reverse polarity while too fast
        if (state_reg == CSC_SERVO || state_reg == CSC_STOP) begin
            mot_next.on   = 1'b1;
            mot_next.full = 1'b0;
            mot_next.fwd  = too_fast ? !dir_reg : dir_reg;
            if (rem_reg < THR_MID && spd_sel_reg == SPD_15) begin
                spd_sel_next = SPD_6;
            end
            if (rem_reg < THR_FINE) begin
                spd_sel_next = SPD_2;
            end
        end
        // track pulses count down only in the full, servo and stop phases
        if (trk_rise && rem_reg != CNT_ZERO && state_reg inside {CSC_FULL,
                CSC_SERVO, CSC_STOP}) begin
            rem_next = rem_reg - 1'b1;
        end
        unique case (state_reg)
            CSC_IDLE: begin
                if (move_req && first_reg && move_cmd.count != CNT_ZERO) begin
                    rem_next   = move_cmd.count;
                    dir_next   = move_cmd.fwd;
                    det_next   = 1'b1;
                    ready_next = 1'b0;
                    tmr_next   = TMR_W'(BRAKE_CYC);                            // pawl clear wait
                    state_next = CSC_UNLOCK;
                end
            end
            CSC_UNLOCK: begin
                // motor held off until the pawl is clear of the gear
                tmr_next = tmr_reg - 1'b1;
                if (tmr_reg == '0) begin
                    mot_next   = '{on: 1'b1, fwd: dir_reg, full: 1'b1};
                    // a one-track move has no next-to-last pulse, so stop is armed at once
                    state_next = (rem_reg > THR_FULL) ? CSC_FULL :
                                 (rem_reg == CNT_ONE) ? CSC_STOP : CSC_SERVO;
                    spd_sel_next = (rem_reg < THR_MID) ? SPD_6 : SPD_15;
                end
            end
            CSC_FULL: begin
                mot_next = '{on: 1'b1, fwd: dir_reg, full: 1'b1};
                if (rem_reg < THR_FULL) begin
                    spd_sel_next = SPD_15;
                    state_next   = CSC_SERVO;
                end
            end
            CSC_SERVO: begin
                if (trk_fall && rem_reg == CNT_ONE) begin
                    state_next = CSC_STOP;
                end
            end
            CSC_STOP: begin
                // last leading edge already counted to zero; wait its trailing edge
                if (trk_fall && rem_reg == CNT_ZERO) begin
                    det_next   = 1'b0;
                    mot_next   = '0;
                    tmr_next   = TMR_W'(LOCK_DLY);
                    set_next   = TMR_W'(SET_CYC);
                    state_next = CSC_LOCKDLY;
                end
            end
            CSC_LOCKDLY: begin
                tmr_next = tmr_reg - 1'b1;
                if (tmr_reg == '0) begin
                    mot_next   = '{on: 1'b1, fwd: !dir_reg, full: 1'b1};
                    tmr_next   = TMR_W'(BRAKE_CYC);
                    state_next = CSC_BRAKE;
                end
            end
            CSC_BRAKE: begin
                tmr_next = tmr_reg - 1'b1;
                if (tmr_reg == '0) begin
                    mot_next   = '0;
                    state_next = CSC_SETTLE;
                end
            end
            CSC_SETTLE: begin
                if (set_reg == '0) begin
                    ready_next = 1'b1;
                    state_next = CSC_IDLE;
                end
            end
            CSC_PURGE: begin
                // the purge runs only while the pack stays above 1900 rpm
                if (!r1900_s) begin
                    tmr_next = TMR_W'(PRG_CYC);
                end else if (tmr_reg != '0) begin
                    tmr_next = tmr_reg - 1'b1;
                end else if (speed_ok) begin
                    det_next   = 1'b1;
                    tmr_next   = TMR_W'(BRAKE_CYC);
                    state_next = CSC_LOADFWD;
                end
            end
            CSC_LOADFWD: begin
                // wait for pawl clear, then forward at 6 ips with cam engaged
                if (tmr_reg != '0) begin
                    tmr_next = tmr_reg - 1'b1;
                end else begin
                    spd_sel_next = SPD_6;
                    mot_next = '{on: 1'b1, fwd: !too_fast, full: 1'b0};
                    cam_next = 1'b1;
                end
                if (loaded_s) begin
                    cam_next   = 1'b0;
                    state_next = CSC_HOMEREV;
                end
            end
            CSC_HOMEREV: begin
                spd_sel_next = SPD_6;
                mot_next = '{on: 1'b1, fwd: too_fast, full: 1'b0};
                if (home_s) begin
                    spd_sel_next = SPD_2;
                    state_next   = CSC_HOMEFWD;
                end
            end
            CSC_HOMEFWD: begin
                mot_next = '{on: 1'b1, fwd: !too_fast, full: 1'b0};
                // first trailing track edge inside the data area is cylinder 00
                if (!home_s && trk_fall) begin
                    det_next   = 1'b0;
                    mot_next   = '0;
                    first_next = 1'b1;
                    dir_next   = 1'b1;
                    tmr_next   = TMR_W'(LOCK_DLY);
                    set_next   = TMR_W'(SET_CYC);
                    state_next = CSC_LOCKDLY;
                end
            end
            CSC_UNLOAD: begin
                // heads off; restart the purge once the carriage reaches home
                mot_next = '{on: 1'b1, fwd: 1'b0, full: 1'b0};
                if (home_s) begin
                    mot_next   = '0;
                    det_next   = 1'b0;
                    tmr_next   = TMR_W'(PRG_CYC);
                    state_next = CSC_PURGE;
                end
            end
            default: state_next = CSC_UNLOAD;
        endcase
        // loss of power or speed once loading has begun unloads the heads
        if (!speed_ok && (first_reg || state_reg == CSC_LOADFWD
                || state_reg == CSC_HOMEREV || state_reg == CSC_HOMEFWD)) begin
            latch_next = 1'b0;
            cam_next   = 1'b0;
            ready_next = 1'b0;
            first_next = 1'b0;
            det_next   = 1'b1;
            state_next = CSC_UNLOAD;
        end
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg    <= CSC_PURGE;
            rem_reg      <= CNT_ZERO;
            dir_reg      <= 1'b0;
            trk_prev_reg <= 1'b0;
            tmr_reg      <= TMR_W'(PRG_CYC);
            set_reg      <= '0;
            cam_reg      <= 1'b0;
            latch_reg    <= 1'b0;
            ready_reg    <= 1'b0;
            det_reg      <= 1'b0;
            mot_reg      <= '0;
            spd_sel_reg  <= SPD_15;
            first_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            rem_reg      <= rem_next;
            dir_reg      <= dir_next;
            trk_prev_reg <= trk_prev_next;
            tmr_reg      <= tmr_next;
            set_reg      <= set_next;
            cam_reg      <= cam_next;
            latch_reg    <= latch_next;
            ready_reg    <= ready_next;
            det_reg      <= det_next;
            mot_reg      <= mot_next;
            spd_sel_reg  <= spd_sel_next;
            first_reg    <= first_next;
        end
    end

    assign motor        = mot_reg;
    assign detent_sol   = det_reg;
    assign cam_sol      = cam_reg;
    assign latch_sol    = latch_reg;
    assign drive_ready  = ready_reg && loaded_s;
    assign heads_loaded = latch_reg && loaded_s;
    assign data_enable  = data_req && ready_reg && latch_reg && loaded_s;

endmodule : csc_seek_ctrl

// ===== sim/csc_seek_ctrl_sva.sv
module csc_seek_ctrl_sva
    import csc_pkg::*;
#(
    parameter int unsigned LOCK_DLY = 50      // pawl fall delay, cycles
) (
    input wire logic       clk,               // clock
    input wire logic       rst_n,             // sync reset
    input wire logic       move_req,          // move strobe
    input wire csc_cmd_s   move_cmd,          // move command
    input wire logic       power_ok_pin,      // power good
    input wire logic       loaded_pin,        // loaded switch
    input wire csc_motor_s motor,             // motor drive
    input wire logic       detent_sol,        // detent solenoid
    input wire logic       cam_sol,           // cam latch
    input wire logic       latch_sol,         // loaded latch
    input wire logic       drive_ready,       // ready
    input wire logic       data_enable,       // data gate
    input wire logic       heads_loaded       // loaded status
);
    timeunit 1ns;
    timeprecision 1ns;
    // brake window: pawl delay with slack for the registered outputs
    localparam int B_LO = LOCK_DLY - 2;
    localparam int B_HI = LOCK_DLY + 4;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_data_gate; data_enable |-> heads_loaded && drive_ready; endproperty
    a_data_gate: assert property (p_data_gate) else $error("data gate open");
    // the motor must stay off while the pawl is still withdrawing
    property p_unlock; move_req && drive_ready && move_cmd.count != 8'h00
        |=> detent_sol && !motor.on [*8]; endproperty
    a_unlock: assert property (p_unlock) else $error("move did not unlock first");
    property p_lock_off; $fell(detent_sol) && heads_loaded |-> !motor.on; endproperty
    a_lock_off: assert property (p_lock_off) else $error("motor on at lock");
    property p_brake; $fell(detent_sol) && heads_loaded
        |-> ##[B_LO:B_HI] motor.on && motor.full; endproperty
    a_brake: assert property (p_brake) else $error("no brake pulse");
    property p_settle; $fell(detent_sol) && heads_loaded |-> !drive_ready [*8]; endproperty
    a_settle: assert property (p_settle) else $error("ready too early");
    property p_unload; $fell(power_ok_pin) |-> ##[1:5] !latch_sol && !heads_loaded; endproperty
    a_unload: assert property (p_unload) else $error("heads kept on power loss");
    property p_cam_drop; $rose(loaded_pin) && cam_sol |-> ##[1:5] !cam_sol; endproperty
    a_cam_drop: assert property (p_cam_drop) else $error("cam held after load");
    property p_cam_fwd; $rose(cam_sol) |-> ##[0:2] motor.on && motor.fwd; endproperty
    a_cam_fwd: assert property (p_cam_fwd) else $error("cam without forward motion");
endmodule : csc_seek_ctrl_sva

bind csc_seek_ctrl csc_seek_ctrl_sva #(.LOCK_DLY(LOCK_DLY)) csc_seek_ctrl_sva_i (
    .clk(clk), .rst_n(rst_n), .move_req(move_req), .move_cmd(move_cmd),
    .power_ok_pin(power_ok_pin), .loaded_pin(loaded_pin), .motor(motor),
    .detent_sol(detent_sol), .cam_sol(cam_sol), .latch_sol(latch_sol),
    .drive_ready(drive_ready), .data_enable(data_enable), .heads_loaded(heads_loaded));

// ===== sim/csc_ctrl_model.sv
// controller side: one move strobe on request, only while the drive is ready
module csc_ctrl_model
    import csc_pkg::*;
(
    input  wire logic     clk,         // clock
    input  wire logic     go,          // bench asks for a move
    input  wire csc_cmd_s cmd_in,      // move to send
    input  wire logic     drive_ready, // drive ready
    output logic          move_req,    // move strobe
    output csc_cmd_s      move_cmd     // move command
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        move_req = 1'h0;
        move_cmd = '0;
    end
    // idle command lines toggle so a stale count can never pass for a real one
    always @(posedge clk) begin
        move_req <= go && drive_ready;
        move_cmd <= (go && drive_ready) ? cmd_in : ~move_cmd;
    end
endmodule : csc_ctrl_model

// ===== sim/carriage_seek_control_tb.sv
module carriage_seek_control_tb;
    import csc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'h0, rst_n, go, trk_pin, home_pin, loaded_pin, data_req;
    logic       rpm1900_pin, rpm2400_pin, power_ok_pin, move_req, spd_pin;
    logic       detent_sol, cam_sol, latch_sol, drive_ready, data_enable, heads_loaded;
    csc_cmd_s   move_cmd, cmd_in;  // command to dut and to the model
    csc_motor_s motor;             // motor drive seen
    int         n_errors = 0, total_checks = 0;
    always #5 clk = ~clk;
    // shortened counts keep the run brief; lock delay stays below settle
    csc_seek_ctrl #(.LOCK_DLY(50), .BRAKE_CYC(20), .SET_CYC(200), .PRG_CYC(40)) csc_seek_ctrl_i (
        .clk(clk), .rst_n(rst_n), .move_req(move_req), .move_cmd(move_cmd),
        .trk_pin(trk_pin), .spd_pin(spd_pin), .home_pin(home_pin), .rpm1900_pin(rpm1900_pin),
        .rpm2400_pin(rpm2400_pin), .power_ok_pin(power_ok_pin), .loaded_pin(loaded_pin),
        .data_req(data_req), .motor(motor), .detent_sol(detent_sol), .cam_sol(cam_sol),
        .latch_sol(latch_sol), .drive_ready(drive_ready), .data_enable(data_enable),
        .heads_loaded(heads_loaded));
    csc_ctrl_model csc_ctrl_model_i (.clk(clk), .go(go), .cmd_in(cmd_in),
        .drive_ready(drive_ready), .move_req(move_req), .move_cmd(move_cmd));
    task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask : ticks
    // track cell pulses, long enough to pass the input synchronisers
    task automatic tracks(input int n);
        repeat (n) begin
            trk_pin = 1'h1;
            ticks(6);
            trk_pin = 1'h0;
            ticks(6);
        end
    endtask : tracks
    task automatic first_seek;
        ticks(20);
        chk("latch_early", latch_sol, 1'h0);
        for (int k = 0; k < 300 && cam_sol !== 1'h1; k++) ticks(1);
        chk("cam_on", cam_sol, 1'h1);
        chk("load_fwd", motor.fwd, 1'h1);
        chk("latch_on", latch_sol, 1'h1);
        home_pin = 1'h0;
        loaded_pin = 1'h1;
        for (int k = 0; k < 50 && !(motor.on && !motor.fwd); k++) ticks(1);
        chk("cam_off", cam_sol, 1'h0);
        chk("retract", motor.fwd, 1'h0);
        home_pin = 1'h1;
        for (int k = 0; k < 50 && motor.fwd !== 1'h1; k++) ticks(1);
        chk("to_zero", motor.fwd, 1'h1);
        chk("latch_hold", latch_sol, 1'h1);
        home_pin = 1'h0;
        tracks(1);
        for (int k = 0; k < 600 && drive_ready !== 1'h1; k++) ticks(1);
        chk("first_ready", drive_ready, 1'h1);
        chk("loaded", heads_loaded, 1'h1);
    endtask : first_seek
    task automatic do_move(input logic fwd, input logic [7:0] n);
        cmd_in = '{fwd: fwd, count: n};
        go = 1'h1;
        ticks(1);
        go = 1'h0;
        ticks(2);
        chk("unlock", detent_sol, 1'h1);
        ticks(25);
        chk("polarity", motor.fwd, fwd);
        chk("drive_on", motor.on, 1'h1);
        if (n > 8'h40) chk("full", motor.full, 1'h1);
        chk("busy", drive_ready, 1'h0);
        chk("data_busy", data_enable, 1'h0);
        // two quick speed ring pulses read as overspeed: the servo turns to braking
        if (n < 8'h10) begin
            repeat (2) begin
                spd_pin = 1'h1;
                ticks(3);
                spd_pin = 1'h0;
                ticks(3);
            end
            chk("brake_pol", motor.fwd, !fwd);
        end
        tracks(n);
        for (int k = 0; k < 600 && drive_ready !== 1'h1; k++) ticks(1);
        chk("ready", drive_ready, 1'h1);
        chk("locked", detent_sol, 1'h0);
        chk("data_on", data_enable, 1'h1);
    endtask : do_move
    task automatic power_loss;
        power_ok_pin = 1'h0;
        ticks(6);
        chk("unload", latch_sol, 1'h0);
        chk("data_off", data_enable, 1'h0);
    endtask : power_loss
    task automatic tally_and_finish;
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst_n, go, trk_pin, loaded_pin, spd_pin} = 5'h00;
        {home_pin, rpm1900_pin, rpm2400_pin, power_ok_pin, data_req} = 5'h1F;
        cmd_in = '0;
        ticks(3);
        rst_n = 1'h1;
        first_seek;
        do_move(1'h1, 8'h46);
        do_move(1'h0, 8'h03);
        power_loss;
        tally_and_finish;
    end
    // cut a hang short well after the tests should have ended
    initial begin
        #300000;
        n_errors++;
        tally_and_finish;
    end
endmodule : carriage_seek_control_tb
